//--- rtl/beslat_top.sv
// Per-bundle latched event status of the circuit_over_packet_engine, with AXI4-Lite access.
// Assumes event reports synchronous to mclk, one of each kind per cycle at most.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "beslat_map.svh"

// What this block does
// - Structured-with-CAS SAToP/CESoPSN packet with wrong frame count sets rx bit 4.
// - AAL1 PDU with bad sequence number or header protection sets rx bit 3.
// - SAToP/CESoPSN packet ahead within window but no buffer space sets rx bit 3.
// - HDLC sequence error outside the 32768 window sets rx bit 2.
// - SAToP/CESoPSN/AAL1 repeated sequence or gap beyond limit: discard, rx bit 2.
// - AAL1 sequence error inside the configured lost-packet window sets rx bit 1.
// - HDLC sequence error inside the 32768 window sets rx bit 1.
// - SAToP/CESoPSN packet hitting jitter buffer overrun: discard, rx bit 1.
// - AAL1 PDU with structure pointer mismatch sets rx bit 0.
// - SAToP/CESoPSN duplicate or late packet: discard, rx bit 0.
// - HDLC frame from TDM ending in abort sets tx bit 4.
// - HDLC frame from TDM shorter than 4 bytes including CRC sets tx bit 3.
// - HDLC frame from TDM above configured maximum size sets tx bit 2.
// - HDLC frame from TDM not a whole number of bytes sets tx bit 1.
// - AAL1 or SAToP/CESoPSN frame or multiframe misalignment sets tx bit 0.
// - HDLC frame from TDM failing CRC sets tx bit 0.
// - Frames from TDM dropped for lack of transmit buffers set buffer bit 0.
// - Every status bit stays at 1 after its event until software clears it.
// - Writing 1 clears a status bit, writing 0 leaves it alone.
// - Tables sit at one common base, each register at its listed offset.
// - One register of each table exists for every bundle 0 to 63.
module beslat_top #(
  parameter int NUM_BUNDLES = 64,
  parameter int ADDR_W      = 18
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire beslat_pkg::beslat_rx_evt_t  rx_evt,
  input  wire beslat_pkg::beslat_tx_evt_t  tx_evt,
  input  wire beslat_pkg::beslat_buf_evt_t buf_evt,
  output logic [NUM_BUNDLES-1:0]         rx_discard
);

  localparam int RX_W  = `BESLAT_RX_W;
  localparam int TX_W  = `BESLAT_TX_W;
  localparam logic [31:0] BASE = `BESLAT_BASE_ADDR;

  if (NUM_BUNDLES < 1 || NUM_BUNDLES > 64 || ADDR_W < 17 || ADDR_W > 32)
  begin : g_bad_param
    $error("beslat_top: NUM_BUNDLES must be 1..64 and ADDR_W 17..32");
  end

  // Address decode shared by both channels
  function automatic beslat_pkg::beslat_dec_t decode(input logic [ADDR_W-1:0] a);
    beslat_pkg::beslat_dec_t d;
    logic                    base_hit;
    logic [11:0]             off;
    logic                    idx_ok;
    d         = '0;
    base_hit  = (a[ADDR_W-1:12] == BASE[ADDR_W-1:12]);
    off       = {a[11:2], 2'b00};
    idx_ok    = (int'(off[8:2]) < NUM_BUNDLES);
    d.idx     = off[8:2];
    d.rx      = base_hit && idx_ok && (off[11:9] == `BESLAT_OFF_RX_STATUS >> 9);
    d.tx      = base_hit && idx_ok && (off[11:9] == `BESLAT_OFF_TX_STATUS >> 9);
    d.buf_tab = base_hit && idx_ok && (off[11:9] == `BESLAT_OFF_BUF_STATUS >> 9);
    d.cfg     = base_hit && idx_ok && (off[11:9] == `BESLAT_OFF_BUNDLE_CFG >> 9);
    d.lost      = base_hit && (off == `BESLAT_OFF_LOST_LIMIT);
    d.max_frame = base_hit && (off == `BESLAT_OFF_MAX_FRAME);
    return d;
  endfunction : decode

  // Status and configuration storage
  logic [NUM_BUNDLES-1:0][RX_W-1:0] rx_stat_reg;
  logic [NUM_BUNDLES-1:0][RX_W-1:0] rx_stat_next;
  logic [NUM_BUNDLES-1:0][TX_W-1:0] tx_stat_reg;
  logic [NUM_BUNDLES-1:0][TX_W-1:0] tx_stat_next;
  logic [NUM_BUNDLES-1:0]           buf_stat_reg;
  logic [NUM_BUNDLES-1:0]           buf_stat_next;
  logic [NUM_BUNDLES-1:0][2:0]      cfg_reg;
  logic [NUM_BUNDLES-1:0][2:0]      cfg_next;
  logic [15:0]                      lost_limit_reg;
  logic [15:0]                      max_frame_reg;
  logic [NUM_BUNDLES-1:0]           rx_discard_next;

  // Write and read channel state
  logic              aw_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_have_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  wire beslat_pkg::beslat_dec_t wr_dec = decode(aw_addr_reg);
  wire beslat_pkg::beslat_dec_t rd_dec = decode(s_axi_araddr);
  wire wr_mapped = wr_dec.rx || wr_dec.tx || wr_dec.buf_tab || wr_dec.cfg ||
                   wr_dec.lost || wr_dec.max_frame;
  wire rd_mapped = rd_dec.rx || rd_dec.tx || rd_dec.buf_tab || rd_dec.cfg ||
                   rd_dec.lost || rd_dec.max_frame;

  // Only lane 0 holds status bits; upper bits are expected zero and ignored
  wire [7:0]  wr_lane0 = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
  wire [15:0] wr_half  = {w_strb_reg[1] ? w_data_reg[15:8] : max_frame_reg[15:8],
                          w_strb_reg[0] ? w_data_reg[7:0] : max_frame_reg[7:0]};
  wire [15:0] wr_lost  = {w_strb_reg[1] ? w_data_reg[15:8] : lost_limit_reg[15:8],
                          w_strb_reg[0] ? w_data_reg[7:0] : lost_limit_reg[7:0]};

  // Receive event classification by payload type of the reporting bundle
  wire                      rx_in_range = (int'(rx_evt.bundle) < NUM_BUNDLES);
  wire [2:0]                rx_cfg      = rx_in_range ? cfg_reg[rx_evt.bundle] : `BESLAT_CFG_RESET;
  wire beslat_pkg::beslat_ptype_t rx_pt = beslat_pkg::beslat_ptype_t'(rx_cfg[1:0]);
  wire rx_aal1  = rx_evt.valid && rx_in_range && (rx_pt == beslat_pkg::BESLAT_PT_AAL1);
  wire rx_hdlc  = rx_evt.valid && rx_in_range && (rx_pt == beslat_pkg::BESLAT_PT_HDLC);
  wire rx_satop = rx_evt.valid && rx_in_range && (rx_pt == beslat_pkg::BESLAT_PT_SATOP);
  wire rx_cas   = rx_cfg[`BESLAT_CFG_CAS_BIT];

  // Delta is received minus expected; all ones means a repeat of the previous number
  wire sn_err     = rx_evt.sn_check && (rx_evt.sn_delta != 16'h0000);
  wire sn_repeat  = rx_evt.sn_check && (rx_evt.sn_delta == 16'hFFFF);
  wire sn_beyond  = sn_err && (rx_evt.sn_delta > lost_limit_reg);
  wire sn_ahead   = sn_err && !sn_beyond && !sn_repeat;
  wire hdlc_in    = sn_err && ({1'b0, rx_evt.sn_delta} < `BESLAT_HDLC_SN_WINDOW);

  wire set_frame_cnt  = rx_satop && rx_cas && rx_evt.frame_count_err;
  wire set_aal1_hdr   = rx_aal1 && rx_evt.hdr_err;
  wire set_satop_jump = rx_satop && sn_ahead && rx_evt.jb_no_space;
  wire set_hdlc_out   = rx_hdlc && sn_err && !hdlc_in;
  wire set_sn_out     = (rx_satop || rx_aal1) && (sn_repeat || sn_beyond);
  wire set_aal1_in    = rx_aal1 && sn_ahead;
  wire set_hdlc_in    = rx_hdlc && hdlc_in;
  wire set_overrun    = rx_satop && rx_evt.jb_overrun;
  wire set_ptr        = rx_aal1 && rx_evt.ptr_mismatch;
  wire set_late       = rx_satop && rx_evt.dup_or_late;

  wire [RX_W-1:0] rx_set_vec = {
    set_frame_cnt,
    set_aal1_hdr || set_satop_jump,
    set_hdlc_out || set_sn_out,
    set_aal1_in || set_hdlc_in || set_overrun,
    set_ptr || set_late
  };
  // Discard strobe covers the cases where the packet is thrown away
  wire rx_drop = set_sn_out || set_overrun || set_late;

  // Transmit event classification
  wire                      tx_in_range = (int'(tx_evt.bundle) < NUM_BUNDLES);
  wire [2:0]                tx_cfg      = tx_in_range ? cfg_reg[tx_evt.bundle] : `BESLAT_CFG_RESET;
  wire beslat_pkg::beslat_ptype_t tx_pt = beslat_pkg::beslat_ptype_t'(tx_cfg[1:0]);
  wire tx_ok      = tx_evt.valid && tx_in_range;
  wire tx_hdlc_fe = tx_ok && (tx_pt == beslat_pkg::BESLAT_PT_HDLC) && tx_evt.frame_end;
  wire tx_framed  = tx_ok && ((tx_pt == beslat_pkg::BESLAT_PT_AAL1) ||
                              (tx_pt == beslat_pkg::BESLAT_PT_SATOP));
  wire [12:0] tx_bytes = tx_evt.bit_len[15:3];

  wire set_abort = tx_hdlc_fe && tx_evt.abort;
  wire set_short = tx_hdlc_fe && (tx_bytes < `BESLAT_MIN_FRAME_BYTES);
  wire set_long  = tx_hdlc_fe && ({3'b000, tx_bytes} > max_frame_reg);
  wire set_align = tx_hdlc_fe && (tx_evt.bit_len[2:0] != 3'h0);
  wire set_frm   = tx_framed && tx_evt.framing_mismatch;
  wire set_crc   = tx_hdlc_fe && tx_evt.crc_err;

  wire [TX_W-1:0] tx_set_vec = {set_abort, set_short, set_long, set_align, set_frm || set_crc};

  wire buf_ok = buf_evt.valid && (int'(buf_evt.bundle) < NUM_BUNDLES);

  // Per-bundle latch update; set wins over a clear in the same cycle
  for (genvar b = 0; b < NUM_BUNDLES; b++)
  begin : g_bundle
    wire            wr_here = wr_fire && (wr_dec.idx == 7'(b));
    wire [RX_W-1:0] rx_clr  = (wr_here && wr_dec.rx) ? wr_lane0[RX_W-1:0] : '0;
    wire [TX_W-1:0] tx_clr  = (wr_here && wr_dec.tx) ? wr_lane0[TX_W-1:0] : '0;
    wire            bf_clr  = wr_here && wr_dec.buf_tab && wr_lane0[`BESLAT_BUF_SHORTAGE_BIT];
    wire            rx_hit  = rx_evt.bundle == 6'(b);
    wire            tx_hit  = tx_evt.bundle == 6'(b);
    wire [RX_W-1:0] rx_set  = rx_hit ? rx_set_vec : '0;
    wire [TX_W-1:0] tx_set  = tx_hit ? tx_set_vec : '0;
    wire            bf_set  = buf_ok && (buf_evt.bundle == 6'(b));
    assign rx_stat_next[b]  = (rx_stat_reg[b] & ~rx_clr) | rx_set;
    assign tx_stat_next[b]  = (tx_stat_reg[b] & ~tx_clr) | tx_set;
    assign buf_stat_next[b] = (buf_stat_reg[b] & ~bf_clr) | bf_set;
    assign cfg_next[b]      = (wr_here && wr_dec.cfg && w_strb_reg[0]) ?
                              w_data_reg[2:0] : cfg_reg[b];
    assign rx_discard_next[b] = rx_drop && rx_hit;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rx_stat_reg  <= {NUM_BUNDLES{`BESLAT_RX_RESET}};
      tx_stat_reg  <= {NUM_BUNDLES{`BESLAT_TX_RESET}};
      buf_stat_reg <= {NUM_BUNDLES{`BESLAT_BUF_RESET}};
      cfg_reg      <= {NUM_BUNDLES{`BESLAT_CFG_RESET}};
      rx_discard   <= '0;
    end
    else
    begin
      rx_stat_reg  <= rx_stat_next;
      tx_stat_reg  <= tx_stat_next;
      buf_stat_reg <= buf_stat_next;
      cfg_reg      <= cfg_next;
      rx_discard   <= rx_discard_next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lost_limit_reg <= `BESLAT_LOST_RESET;
      max_frame_reg  <= `BESLAT_MAX_FRAME_RESET;
    end
    else if (wr_fire)
    begin
      if (wr_dec.lost)
        lost_limit_reg <= wr_lost;
      if (wr_dec.max_frame)
        max_frame_reg <= wr_half;
    end
  end

  // Write address and data may come in either order; the response waits for both
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `BESLAT_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? `BESLAT_RESP_OKAY : `BESLAT_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Read mux; unmapped addresses answer zero with a slave error
  wire [5:0]  rd_i    = rd_dec.idx[5:0];
  wire [31:0] rd_word =
    rd_dec.rx        ? {27'h0, rx_stat_reg[rd_i]} :
    rd_dec.tx        ? {27'h0, tx_stat_reg[rd_i]} :
    rd_dec.buf_tab   ? {31'h0, buf_stat_reg[rd_i]} :
    rd_dec.cfg       ? {29'h0, cfg_reg[rd_i]} :
    rd_dec.lost      ? {16'h0, lost_limit_reg} :
    rd_dec.max_frame ? {16'h0, max_frame_reg} : 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `BESLAT_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? `BESLAT_RESP_OKAY : `BESLAT_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule : beslat_top

//--- shared/beslat_map.svh
// Address map, field positions, reset values and fixed limits of the bundle event status latches.
// Assumes the includer compares addresses against a 32-bit base.
`ifndef BESLAT_MAP_SVH
`define BESLAT_MAP_SVH

`define BESLAT_BASE_ADDR        32'h0001_2000
`define BESLAT_OFF_RX_STATUS    12'h000
`define BESLAT_OFF_TX_STATUS    12'h200
`define BESLAT_OFF_BUF_STATUS   12'h400
`define BESLAT_OFF_BUNDLE_CFG   12'h800
`define BESLAT_OFF_LOST_LIMIT   12'hA00
`define BESLAT_OFF_MAX_FRAME    12'hA04

`define BESLAT_RX_W             5
`define BESLAT_TX_W             5
`define BESLAT_BUF_W            1

`define BESLAT_RX_FRAME_CNT_BIT 4
`define BESLAT_RX_HDR_JUMP_BIT  3
`define BESLAT_RX_SN_OUT_BIT    2
`define BESLAT_RX_SN_IN_BIT     1
`define BESLAT_RX_PTR_LATE_BIT  0

`define BESLAT_TX_ABORT_BIT     4
`define BESLAT_TX_SHORT_BIT     3
`define BESLAT_TX_LONG_BIT      2
`define BESLAT_TX_ALIGN_BIT     1
`define BESLAT_TX_CRC_FRM_BIT   0

`define BESLAT_BUF_SHORTAGE_BIT 0

`define BESLAT_CFG_CAS_BIT      2

`define BESLAT_RX_RESET         5'h00
`define BESLAT_TX_RESET         5'h00
`define BESLAT_BUF_RESET        1'h0
`define BESLAT_CFG_RESET        3'h3
`define BESLAT_LOST_RESET       16'h0010
`define BESLAT_MAX_FRAME_RESET  16'h0600

`define BESLAT_HDLC_SN_WINDOW   17'h08000
`define BESLAT_MIN_FRAME_BYTES  13'h0004

`define BESLAT_RESP_OKAY        2'h0
`define BESLAT_RESP_SLVERR      2'h2

`endif

//--- shared/beslat_pkg.sv
// Types shared by the bundle event status latches and their surroundings.
// Assumes bundle indices of six bits.
package beslat_pkg;

  typedef enum logic [1:0] {
    BESLAT_PT_AAL1,
    BESLAT_PT_HDLC,
    BESLAT_PT_SATOP,
    BESLAT_PT_NONE
  } beslat_ptype_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  bundle;
    logic        sn_check;
    logic [15:0] sn_delta;
    logic        hdr_err;
    logic        ptr_mismatch;
    logic        jb_no_space;
    logic        jb_overrun;
    logic        dup_or_late;
    logic        frame_count_err;
  } beslat_rx_evt_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  bundle;
    logic        frame_end;
    logic        abort;
    logic        crc_err;
    logic [15:0] bit_len;
    logic        framing_mismatch;
  } beslat_tx_evt_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  bundle;
  } beslat_buf_evt_t;

  typedef struct packed {
    logic        rx;
    logic        tx;
    logic        buf_tab;
    logic        cfg;
    logic        lost;
    logic        max_frame;
    logic [6:0]  idx;
  } beslat_dec_t;

endpackage : beslat_pkg

//--- tb/beslat_checker.sv
// Port-level assertions for the bundle event status latches.
// Assumes a bind onto beslat_top with a synchronous, active-high reset.
`timescale 1ns/10ps
module beslat_checker #(
  parameter int NUM_BUNDLES = 64,
  parameter int ADDR_W      = 18
) (
  input wire logic                       mclk,
  input wire logic                       reset,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic [ADDR_W-1:0]          s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire beslat_pkg::beslat_rx_evt_t rx_evt,
  input wire logic [NUM_BUNDLES-1:0]     rx_discard
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire ar_go   = s_axi_arvalid && s_axi_arready;
  wire in_base = s_axi_araddr[ADDR_W-1:12] == 'h12;

  AST_RD_MAPPED:
  assert property (ar_go && in_base && s_axi_araddr[11:2] < NUM_BUNDLES
    |=> s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata[31:5] == 27'h0)
    else $error("status read not answered OKAY with clear upper bits");
  AST_RD_UNMAPPED:
  assert property (ar_go && (!in_base || s_axi_araddr[11:8] == 4'h1)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_BUF_UPPER:
  assert property (ar_go && in_base && s_axi_araddr[11:8] == 4'h4 |=> s_axi_rdata[31:1] == 31'h0)
    else $error("buffer status upper bits not zero");
  AST_WR_RESP:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after acceptance");
  AST_AW_BLOCK:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_AR_BLOCK:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_DISC_CAUSE:
  assert property (rx_discard != '0 |-> $past(rx_evt.valid)
    && (rx_discard == (NUM_BUNDLES'(1) << $past(rx_evt.bundle))))
    else $error("discard pulse without matching receive event");
  AST_DISC_NONE:
  assert property (rx_evt.valid && !rx_evt.sn_check && !rx_evt.jb_overrun && !rx_evt.dup_or_late
    |=> rx_discard == '0)
    else $error("discard pulse for a non-discarding event");
  AST_DISC_ONE:
  assert property ($onehot0(rx_discard))
    else $error("more than one bundle discarded at once");
endmodule : beslat_checker

//--- tb/beslat_bench.sv
// Self-checking bench for the bundle event status latches: bus master, events, monitor.
// Assumes beslat_top with 64 bundles and the map header on the include path.
`timescale 1ns/10ps
`include "beslat_map.svh"
module beslat_bench;
  logic                        mclk = 1'b0;
  logic                        reset = 1'b1;
  logic [17:0]                 awaddr = '0, araddr = '0;
  logic [31:0]                 wdata = '0, rdata;
  logic                        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                        arvalid = 1'b0, rready = 1'b0;
  logic                        awready, wready, bvalid, arready, rvalid;
  logic [1:0]                  bresp, rresp;
  beslat_pkg::beslat_rx_evt_t  rx = '0;
  beslat_pkg::beslat_tx_evt_t  tx = '0;
  beslat_pkg::beslat_buf_evt_t bf = '0;
  logic [63:0]                 disc;
  logic [63:0]                 rq[$], bq[$], dq[$];
  logic [15:0]                 lim;
  int                          fail_count = 0;
  int                          n_compared = 0;
  int                          seed = 32'h1129;
  int                          ba, bs;
  localparam logic [17:0]      BASE = 18'(`BESLAT_BASE_ADDR);

  always #5 mclk = ~mclk;

  beslat_top uut (
    .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_evt(rx), .tx_evt(tx), .buf_evt(bf), .rx_discard(disc));

  task automatic check(input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (e !== g)
    begin
      fail_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // One transfer at a time; ready/valid held until the handshake edge
  task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    if (w)
      bq.push_back(r);
    else
      rq.push_back({r, d});
    @(posedge mclk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= w;
    wvalid  <= w;
    bready  <= w;
    arvalid <= !w;
    rready  <= !w;
    for (int k = 0; k < 100; k++)
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (bvalid && bready || rvalid && rready)
        break;
      if (k == 99)
      begin
        fail_count++;
        summarize();
      end
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask : bus

  task automatic ev(input beslat_pkg::beslat_rx_evt_t r, input beslat_pkg::beslat_tx_evt_t t,
                    input logic [6:0] b);
    @(posedge mclk);
    rx <= r;
    tx <= t;
    bf <= b;
    @(posedge mclk);
    rx <= '0;
    tx <= '0;
    bf <= '0;
  endtask : ev

  // Flags: header, pointer, no space, overrun, duplicate/late, frame count
  function automatic beslat_pkg::beslat_rx_evt_t mr(int b, logic [15:0] d, logic [5:0] f);
    return {1'b1, 6'(b), d != 16'h0, d, f};
  endfunction : mr

  // Latched, survives a write of 0, clears on a write of 1
  task automatic chk(input logic [11:0] o, input int n, input logic [4:0] m);
    logic [17:0] a;
    logic [4:0]  w;
    a = BASE + 18'(o) + 18'(n * 4);
    w = (o == 12'h400) ? 5'h01 : 5'h1F;
    // Read before any clear, so a wrongly set extra bit is seen
    bus(1'b0, a, {27'h0, m}, 2'h0);
    bus(1'b1, a, {27'h0, w & ~m}, 2'h0);
    bus(1'b0, a, {27'h0, m}, 2'h0);
    bus(1'b1, a, {27'h0, m}, 2'h0);
    bus(1'b0, a, 32'h0, 2'h0);
  endtask : chk

  task automatic rxc(input beslat_pkg::beslat_rx_evt_t r, input logic [4:0] m, input logic d);
    if (d)
      dq.push_back(64'h1 << r.bundle);
    ev(r, '0, 7'h0);
    chk(12'h000, int'(r.bundle), m);
  endtask : rxc

  task automatic txc(input int n, input logic [2:0] f, input logic [15:0] l, input logic g,
                     input logic [4:0] m);
    ev('0, {1'b1, 6'(n), f, l, g}, 7'h0);
    chk(12'h200, n, m);
  endtask : txc

  always @(posedge mclk)
  begin
    if (rvalid && rready)
      check(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready)
      check(bq.pop_front(), bresp);
    // Discard output is unknown until the first reset edge has landed
    if (!reset && disc !== 64'h0)
      check(dq.pop_front(), disc);
  end

  initial
  begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    ba  = {$random(seed)} % 32;
    bs  = 32 + {$random(seed)} % 31;
    lim = 16'(2 + {$random(seed)} % 100);
    for (int i = 0; i < 3; i++)
      bus(1'b0, BASE + 18'(i * 12'h200 + 12'hFC), 32'h0, 2'h0);
    bus(1'b0, BASE + 18'h100, 32'h0, 2'h2);
    bus(1'b1, 18'h13000, 32'h1F, 2'h2);
    bus(1'b1, BASE + 18'h800 + 18'(ba * 4), 32'h0, 2'h0);
    bus(1'b1, BASE + 18'h8FC, 32'h1, 2'h0);
    bus(1'b1, BASE + 18'h800 + 18'(bs * 4), 32'h6, 2'h0);
    bus(1'b1, BASE + 18'hA00, {16'h0, lim}, 2'h0);
    bus(1'b1, BASE + 18'hA04, 32'h8, 2'h0);
    rxc(mr(ba, 16'h0, 6'h20), 5'h08, 1'b0);
    rxc(mr(ba, 16'h0, 6'h10), 5'h01, 1'b0);
    rxc(mr(ba, lim, 6'h00), 5'h02, 1'b0);
    rxc(mr(ba, lim + 16'h1, 6'h00), 5'h04, 1'b1);
    rxc(mr(ba, 16'hFFFF, 6'h00), 5'h04, 1'b1);
    rxc(mr(63, 16'h7FFF, 6'h00), 5'h02, 1'b0);
    rxc(mr(63, 16'h8000, 6'h00), 5'h04, 1'b0);
    rxc(mr(63, 16'h0, 6'h30), 5'h00, 1'b0);
    rxc(mr(bs, lim, 6'h08), 5'h08, 1'b0);
    rxc(mr(bs, 16'h0, 6'h04), 5'h02, 1'b1);
    rxc(mr(bs, 16'h0, 6'h02), 5'h01, 1'b1);
    rxc(mr(bs, 16'h0, 6'h01), 5'h10, 1'b0);
    rxc(mr(bs, lim + 16'h1, 6'h00), 5'h04, 1'b1);
    txc(63, 3'b110, 16'd64, 1'b0, 5'h10);
    txc(63, 3'b100, 16'd24, 1'b0, 5'h08);
    txc(63, 3'b100, 16'd32, 1'b0, 5'h00);
    txc(63, 3'b100, 16'd72, 1'b0, 5'h04);
    txc(63, 3'b100, 16'd67, 1'b0, 5'h02);
    txc(63, 3'b101, 16'd64, 1'b0, 5'h01);
    txc(ba, 3'b000, 16'd0, 1'b1, 5'h01);
    txc(bs, 3'b000, 16'd0, 1'b1, 5'h01);
    ev('0, '0, {1'b1, 6'(bs)});
    chk(12'h400, bs, 5'h01);
    // Event lands on the clear's fire edge: the set must win
    ev('0, '0, {1'b1, 6'(ba)});
    fork
      bus(1'b1, BASE + 18'h400 + 18'(ba * 4), 32'h1, 2'h0);
      begin
        repeat (1) @(posedge mclk);
        ev('0, '0, {1'b1, 6'(ba)});
      end
    join
    bus(1'b0, BASE + 18'h400 + 18'(ba * 4), 32'h1, 2'h0);
    repeat (2) @(posedge mclk);
    check(64'h0, 64'(dq.size()));
    summarize();
  end
endmodule : beslat_bench

bind beslat_top beslat_checker #(.NUM_BUNDLES(NUM_BUNDLES), .ADDR_W(ADDR_W)) u_chk (
  .mclk(mclk), .reset(reset), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .rx_evt(rx_evt), .rx_discard(rx_discard));
